// file: verilog/csad_top.sv
// Management bus target for the cartridge: EEPROM, info ROM and sensor
`timescale 1ns/1ps
module csad_top
    import csad_pkg::*;
#(
    parameter int         SCRATCH_DEPTH = 128,
    parameter logic [7:0] FORMAT_REV    = 8'h01
)(
    input  logic            clk_sys,
    input  logic            rst,
    input  logic            mgmt_bus_clock,
    input  logic            mgmt_bus_data_in,
    output logic            mgmt_bus_data_out,
    output logic            mgmt_bus_data_oe,
    input  csad_slot_pins_s slot_select_pins,
    input  logic            scratch_write_protect,
    input  logic [7:0]      diode_temperature,
    output logic            thermal_alert_out_n
);

    localparam int SAW = $clog2(SCRATCH_DEPTH);

    if (SCRATCH_DEPTH < 2 || SCRATCH_DEPTH > 256 ||
        (1 << SAW) != SCRATCH_DEPTH) begin
        $error("SCRATCH_DEPTH must be a power of two from 2 to 256");
    end

    // ---------------- Decoding functions ----------------

    function automatic csad_slot_s resolve_slot(csad_slot_pins_s p);
        csad_slot_s s;
        s.bit0 = p.bit0_drv & p.bit0_val;
        s.bit1 = p.bit1_drv & p.bit1_val;
        if (!p.tri_drv) begin
            s.tri_state = TRI_FLOAT;
        end else if (p.tri_val) begin
            s.tri_state = TRI_HIGH;
        end else begin
            s.tri_state = TRI_LOW;
        end
        return s;
    endfunction

    function automatic csad_target_e decode_addr(logic [7:0] a,
                                                 csad_slot_s s);
        logic [3:0]   sns_nib;
        logic         mem_hit;
        logic         sns_hit;
        csad_target_e t;
        case (s.tri_state)
            TRI_LOW:   sns_nib = SNS_NIBBLE_LOW;
            TRI_FLOAT: sns_nib = SNS_NIBBLE_FLOAT;
            TRI_HIGH:  sns_nib = SNS_NIBBLE_HIGH;
            default:   sns_nib = RESERVED_NIBBLE;
        endcase
        mem_hit = (a[7:4] == MEM_NIBBLE)
               && (a[ADDR_SLOT1_BIT] == s.bit1)
               && (a[ADDR_SLOT0_BIT] == s.bit0);
        sns_hit = (a[7:4] == sns_nib)
               && (a[ADDR_SNS_HI_BIT] == (s.tri_state == TRI_HIGH))
               && (a[ADDR_SNS_MI_BIT] == s.bit1)
               && (a[ADDR_SNS_LO_BIT] == (s.tri_state == TRI_FLOAT));
        // Reserved nibble 0000 can never match either pattern
        if (mem_hit) begin
            t = (a[ADDR_SEL_BIT] == SEL_ROM) ? TGT_ROM
                                             : TGT_SCRATCH;
        end else if (sns_hit) begin
            t = TGT_SENSOR;
        end else begin
            t = TGT_NONE;
        end
        return t;
    endfunction

    function automatic logic [7:0] rom_header(logic [7:0] ofs);
        case (ofs)
            OFS_FORMAT_REV:  rom_header = FORMAT_REV;
            OFS_SIZE_LO:     rom_header = ROM_SIZE_VALUE[7:0];
            OFS_SIZE_HI:     rom_header = ROM_SIZE_VALUE[15:8];
            OFS_PROC_PTR:    rom_header = PROC_PTR_VALUE;
            OFS_CORE_PTR:    rom_header = CORE_PTR_VALUE;
            OFS_CACHE_PTR:   rom_header = CACHE_PTR_VALUE;
            OFS_CART_PTR:    rom_header = CART_PTR_VALUE;
            OFS_PART_PTR:    rom_header = PART_PTR_VALUE;
            OFS_THERM_PTR:   rom_header = THERM_PTR_VALUE;
            OFS_FEATURE_PTR: rom_header = FEATURE_PTR_VALUE;
            OFS_OTHER_PTR:   rom_header = OTHER_PTR_VALUE;
            default:         rom_header = ZERO_BYTE;
        endcase
    endfunction

    // Sections past the header are blank, so their checksums are zero
    function automatic logic [7:0] rom_byte(logic [7:0] ofs);
        logic [7:0] sum;
        sum = ZERO_BYTE;
        for (int i = 0; i < int'(OFS_HDR_CSUM); i++) begin
            sum = sum + rom_header(8'(i));
        end
        if (ofs == OFS_HDR_CSUM) begin
            rom_byte = ZERO_BYTE - sum;
        end else if (int'(ofs) >= ROM_BYTES) begin
            rom_byte = ZERO_BYTE;
        end else begin
            rom_byte = rom_header(ofs);
        end
    endfunction

    // ---------------- System clock domain ----------------

    logic       scl_meta_reg;
    logic       scl_sync_reg;
    logic       scl_prev_reg;
    logic       sda_meta_reg;
    logic       sda_sync_reg;
    logic       sda_prev_reg;
    logic       hold_reg;
    logic       release_reg;
    logic       rst_link_reg;
    logic       temp_req_reg;
    logic [7:0] temp_pub_reg;
    logic       temp_ack_meta_reg;
    logic       temp_ack_sync_reg;
    logic       thigh_tgl_meta_reg;
    logic       thigh_tgl_sync_reg;
    logic       thigh_tgl_prev_reg;
    logic [7:0] thigh_sys_reg;
    logic       alert_n_reg;

    // Link-domain signals read by the system domain
    logic       temp_ack_reg;
    logic       thigh_tgl_reg;
    logic [7:0] thigh_link_reg;

    wire scl_high   = scl_sync_reg & scl_prev_reg;
    wire bus_start  = scl_high & sda_prev_reg & ~sda_sync_reg;
    wire bus_stop   = scl_high & ~sda_prev_reg & sda_sync_reg;
    wire temp_free  = (temp_ack_sync_reg == temp_req_reg);
    wire thigh_new  = thigh_tgl_sync_reg ^ thigh_tgl_prev_reg;
    wire alert_next = ~(diode_temperature >= thigh_sys_reg);

    always_ff @(posedge clk_sys) begin
        scl_meta_reg <= mgmt_bus_clock;
        scl_sync_reg <= scl_meta_reg;
        scl_prev_reg <= scl_sync_reg;
        sda_meta_reg <= mgmt_bus_data_in;
        sda_sync_reg <= sda_meta_reg;
        sda_prev_reg <= sda_sync_reg;
    end

    // Link engine is held while the bus is idle and pulsed on each start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_reg    <= 1'b1;
            release_reg <= 1'b0;
        end else if (bus_start) begin
            hold_reg    <= 1'b1;
            release_reg <= 1'b1;
        end else if (bus_stop) begin
            hold_reg    <= 1'b1;
            release_reg <= 1'b0;
        end else if (release_reg) begin
            hold_reg    <= 1'b0;
            release_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        rst_link_reg <= rst;
    end

    // Temperature handed to the link side by req/ack toggle handshake
    always_ff @(posedge clk_sys) begin
        temp_ack_meta_reg <= temp_ack_reg;
        temp_ack_sync_reg <= temp_ack_meta_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temp_req_reg <= 1'b0;
            temp_pub_reg <= ZERO_BYTE;
        end else if (temp_free) begin
            temp_req_reg <= ~temp_req_reg;
            temp_pub_reg <= diode_temperature;
        end
    end

    // Threshold comes back as a toggle; word is stable when it lands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            thigh_tgl_meta_reg <= 1'b0;
            thigh_tgl_sync_reg <= 1'b0;
            thigh_tgl_prev_reg <= 1'b0;
        end else begin
            thigh_tgl_meta_reg <= thigh_tgl_reg;
            thigh_tgl_sync_reg <= thigh_tgl_meta_reg;
            thigh_tgl_prev_reg <= thigh_tgl_sync_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            thigh_sys_reg <= THIGH_RESET;
        end else if (thigh_new) begin
            thigh_sys_reg <= thigh_link_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alert_n_reg <= 1'b1;
        end else begin
            alert_n_reg <= alert_next;
        end
    end

    assign thermal_alert_out_n = alert_n_reg;

    // ---------------- Link clock domain ----------------

    csad_slot_pins_s slot_meta_reg;
    csad_slot_pins_s slot_sync_reg;
    logic            wp_meta_reg;
    logic            wp_sync_reg;
    logic            temp_req_meta_reg;
    logic            temp_req_sync_reg;
    logic [7:0]      temp_link_reg;
    logic [3:0]      bit_cnt_reg;
    logic [3:0]      bit_cnt_next;
    logic [7:0]      shift_reg;
    csad_state_e     st_reg;
    csad_state_e     st_next;
    csad_target_e    tgt_reg;
    logic [7:0]      ptr_reg;
    logic [7:0]      ptr_next;
    logic            oe_reg;
    logic            oe_next;
    logic [7:0]      scratch_mem [SCRATCH_DEPTH];

    // Pins are static straps; two link edges settle them
    always_ff @(posedge mgmt_bus_clock or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            slot_meta_reg <= '0;
            slot_sync_reg <= '0;
            wp_meta_reg   <= 1'b1;
            wp_sync_reg   <= 1'b1;
        end else begin
            slot_meta_reg <= slot_select_pins;
            slot_sync_reg <= slot_meta_reg;
            wp_meta_reg   <= scratch_write_protect;
            wp_sync_reg   <= wp_meta_reg;
        end
    end

    wire csad_slot_s   slot_now  = resolve_slot(slot_sync_reg);
    wire csad_target_e addr_tgt  = decode_addr(shift_reg, slot_now);
    wire               ack_slot  = (bit_cnt_reg == BIT_ACK);
    wire               byte_done = ack_slot;
    wire               addr_hit  = (addr_tgt != TGT_NONE);
    wire               is_read   = (shift_reg[ADDR_RW_BIT] == DIR_READ);
    wire               is_mem    = (tgt_reg == TGT_SCRATCH)
                                || (tgt_reg == TGT_ROM);
    wire [SAW-1:0]     mem_idx   = ptr_reg[SAW-1:0];
    wire [2:0]         tx_idx    = ~bit_cnt_reg[2:0];
    wire               host_nack = mgmt_bus_data_in;
    wire               sns_thigh = (ptr_reg == SNS_PTR_THIGH);

    wire scratch_we = byte_done && (st_reg == ST_WDATA)
                   && (tgt_reg == TGT_SCRATCH)
                   && !wp_sync_reg;
    wire thigh_we   = byte_done && (st_reg == ST_WDATA)
                   && (tgt_reg == TGT_SENSOR) && sns_thigh;

    // Info ROM has no write path at all
    wire [7:0] rd_byte = (tgt_reg == TGT_ROM)     ? rom_byte(ptr_reg) :
                         (tgt_reg == TGT_SCRATCH) ? scratch_mem[mem_idx] :
                         sns_thigh                ? thigh_link_reg :
                                                    temp_link_reg;

    assign bit_cnt_next = ack_slot ? BIT_FIRST
                                   : 4'(bit_cnt_reg + 4'h1);

    always_comb begin
        st_next = st_reg;
        if (byte_done) begin
            case (st_reg)
                ST_ADDR: begin
                    if (!addr_hit) begin
                        st_next = ST_IGNORE;
                    end else if (is_read) begin
                        st_next = ST_READ;
                    end else begin
                        st_next = ST_OFFSET;
                    end
                end
                ST_OFFSET: st_next = ST_WDATA;
                ST_WDATA:  st_next = ST_WDATA;
                ST_READ:   st_next = host_nack ? ST_IGNORE : ST_READ;
                ST_IGNORE: st_next = ST_IGNORE;
                default:   st_next = ST_IGNORE;
            endcase
        end
    end

    // Memories auto-increment; sensor pointer stays put
    always_comb begin
        ptr_next = ptr_reg;
        if (byte_done && st_reg == ST_OFFSET) begin
            ptr_next = shift_reg;
        end else if (byte_done && is_mem &&
                     (st_reg == ST_WDATA || st_reg == ST_READ)) begin
            ptr_next = 8'(ptr_reg + 8'h01);
        end
    end

    always_ff @(posedge mgmt_bus_clock or posedge hold_reg) begin
        if (hold_reg) begin
            bit_cnt_reg <= BIT_FIRST;
            st_reg      <= ST_ADDR;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            st_reg      <= st_next;
        end
    end

    // Data enters MSB first; acknowledge slot leaves the byte intact
    always_ff @(posedge mgmt_bus_clock or posedge hold_reg) begin
        if (hold_reg) begin
            shift_reg <= ZERO_BYTE;
        end else if (!ack_slot) begin
            shift_reg <= {shift_reg[6:0], mgmt_bus_data_in};
        end
    end

    always_ff @(posedge mgmt_bus_clock or posedge hold_reg) begin
        if (hold_reg) begin
            tgt_reg <= TGT_NONE;
        end else if (byte_done && st_reg == ST_ADDR) begin
            tgt_reg <= addr_tgt;
        end
    end

    // Pointer survives between frames for current-address reads
    always_ff @(posedge mgmt_bus_clock or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            ptr_reg <= ZERO_BYTE;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge mgmt_bus_clock) begin
        if (scratch_we) begin
            scratch_mem[mem_idx] <= shift_reg;
        end
    end

    always_ff @(posedge mgmt_bus_clock or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            thigh_link_reg <= THIGH_RESET;
            thigh_tgl_reg  <= 1'b0;
        end else if (thigh_we) begin
            thigh_link_reg <= shift_reg;
            thigh_tgl_reg  <= ~thigh_tgl_reg;
        end
    end

    // Temperature only refreshes while the bus clock is running
    always_ff @(posedge mgmt_bus_clock or posedge rst_link_reg) begin
        if (rst_link_reg) begin
            temp_req_meta_reg <= 1'b0;
            temp_req_sync_reg <= 1'b0;
            temp_ack_reg      <= 1'b0;
            temp_link_reg     <= ZERO_BYTE;
        end else begin
            temp_req_meta_reg <= temp_req_reg;
            temp_req_sync_reg <= temp_req_meta_reg;
            if (temp_req_sync_reg != temp_ack_reg) begin
                temp_link_reg <= temp_pub_reg;
                temp_ack_reg  <= temp_req_sync_reg;
            end
        end
    end

    // Falling edge drives: ack low, or read data bits as open drain
    always_comb begin
        oe_next = 1'b0;
        if (ack_slot) begin
            oe_next = (st_reg == ST_ADDR && addr_hit)
                   || (st_reg == ST_OFFSET)
                   || (st_reg == ST_WDATA);
        end else if (st_reg == ST_READ) begin
            oe_next = ~rd_byte[tx_idx];
        end
    end

    always_ff @(negedge mgmt_bus_clock or posedge hold_reg) begin
        if (hold_reg) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        mgmt_bus_data_out <= 1'b0;
    end

    assign mgmt_bus_data_oe = oe_reg;

endmodule

// file: verilog/csad_pkg.sv
// Shared constants and types for the cartridge management bus decoder
package csad_pkg;

    // Address word layout
    localparam int          ADDR_RW_BIT     = 0;
    localparam int          ADDR_SEL_BIT    = 1;
    localparam int          ADDR_SLOT0_BIT  = 2;
    localparam int          ADDR_SLOT1_BIT  = 3;
    localparam int          ADDR_SNS_LO_BIT = 1;
    localparam int          ADDR_SNS_MI_BIT = 2;
    localparam int          ADDR_SNS_HI_BIT = 3;
    localparam logic [3:0]  MEM_NIBBLE       = 4'hA;
    localparam logic [3:0]  SNS_NIBBLE_LOW   = 4'h3;
    localparam logic [3:0]  SNS_NIBBLE_FLOAT = 4'h5;
    localparam logic [3:0]  SNS_NIBBLE_HIGH  = 4'h9;
    localparam logic [3:0]  RESERVED_NIBBLE  = 4'h0;
    localparam logic        SEL_SCRATCH      = 1'b0;
    localparam logic        SEL_ROM          = 1'b1;
    localparam logic        DIR_READ         = 1'b1;

    // Bit counter: eight data bits, then the acknowledge slot
    localparam logic [3:0]  BIT_FIRST = 4'h0;
    localparam logic [3:0]  BIT_ACK   = 4'h8;

    // Information ROM header
    localparam int          ROM_BYTES        = 128;
    localparam logic [7:0]  OFS_FORMAT_REV   = 8'h00;
    localparam logic [7:0]  OFS_SIZE_LO      = 8'h01;
    localparam logic [7:0]  OFS_SIZE_HI      = 8'h02;
    localparam logic [7:0]  OFS_PROC_PTR     = 8'h03;
    localparam logic [7:0]  OFS_CORE_PTR     = 8'h04;
    localparam logic [7:0]  OFS_CACHE_PTR    = 8'h05;
    localparam logic [7:0]  OFS_CART_PTR     = 8'h06;
    localparam logic [7:0]  OFS_PART_PTR     = 8'h07;
    localparam logic [7:0]  OFS_THERM_PTR    = 8'h08;
    localparam logic [7:0]  OFS_FEATURE_PTR  = 8'h09;
    localparam logic [7:0]  OFS_OTHER_PTR    = 8'h0A;
    localparam logic [7:0]  OFS_HDR_CSUM     = 8'h0D;
    localparam logic [15:0] ROM_SIZE_VALUE   = 16'h0080;
    localparam logic [7:0]  PROC_PTR_VALUE   = 8'h0E;
    localparam logic [7:0]  CORE_PTR_VALUE   = 8'h16;
    localparam logic [7:0]  CACHE_PTR_VALUE  = 8'h26;
    localparam logic [7:0]  CART_PTR_VALUE   = 8'h33;
    localparam logic [7:0]  PART_PTR_VALUE   = 8'h3B;
    localparam logic [7:0]  THERM_PTR_VALUE  = 8'h61;
    localparam logic [7:0]  FEATURE_PTR_VALUE = 8'h65;
    localparam logic [7:0]  OTHER_PTR_VALUE  = 8'h79;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;

    // Thermal sensor register pointers
    localparam logic [7:0]  SNS_PTR_TEMP     = 8'h00;
    localparam logic [7:0]  SNS_PTR_THIGH    = 8'h01;
    localparam logic [7:0]  THIGH_RESET      = 8'h50;

    typedef enum logic [1:0] {
        TGT_NONE    = 2'h0,
        TGT_SCRATCH = 2'h1,
        TGT_ROM     = 2'h2,
        TGT_SENSOR  = 2'h3
    } csad_target_e;

    typedef enum logic [1:0] {
        TRI_LOW   = 2'h0,
        TRI_FLOAT = 2'h1,
        TRI_HIGH  = 2'h2
    } csad_tri_e;

    typedef enum logic [4:0] {
        ST_ADDR   = 5'h01,
        ST_OFFSET = 5'h02,
        ST_WDATA  = 5'h04,
        ST_READ   = 5'h08,
        ST_IGNORE = 5'h10
    } csad_state_e;

    // Raw slot select pins: level plus "someone drives it" sense
    typedef struct packed {
        logic tri_drv;
        logic tri_val;
        logic bit1_drv;
        logic bit1_val;
        logic bit0_drv;
        logic bit0_val;
    } csad_slot_pins_s;

    // Resolved slot position
    typedef struct packed {
        csad_tri_e tri_state;
        logic      bit1;
        logic      bit0;
    } csad_slot_s;

endpackage

// file: tb/csad_checker.sv
// Port checker for the management bus decoder, with its bind
`timescale 1ns/1ps
module csad_checker
    import csad_pkg::*;
(
    input logic            clk_sys,
    input logic            rst,
    input logic            mgmt_bus_clock,
    input logic            mgmt_bus_data_in,
    input logic            mgmt_bus_data_out,
    input logic            mgmt_bus_data_oe,
    input csad_slot_pins_s slot_select_pins,
    input logic [7:0]      diode_temperature,
    input logic            thermal_alert_out_n
);
    logic [3:0]      nbit;
    logic [7:0]      sh;
    logic            first;
    logic            pc;
    logic            pd;
    csad_slot_pins_s p;
    assign p = slot_select_pins;
    wire       rise = !pc && mgmt_bus_clock;
    wire       s1   = p.bit1_drv && p.bit1_val;
    wire       s0   = p.bit0_drv && p.bit0_val;
    wire       hi   = p.tri_drv && p.tri_val;
    wire       fl   = !p.tri_drv;
    wire [3:0] snib = fl ? SNS_NIBBLE_FLOAT
                         : (hi ? SNS_NIBBLE_HIGH : SNS_NIBBLE_LOW);
    wire       mem_hit = sh[7:2] == {MEM_NIBBLE, s1, s0};
    wire       sns_hit = sh[7:1] == {snib, hi, s1, fl};
    wire       hit = mem_hit || sns_hit;
    // Raw pins are sampled here; the design syncs its own copy
    always_ff @(posedge clk_sys) begin
        pc <= mgmt_bus_clock;
        pd <= mgmt_bus_data_in;
        if (rst) begin
            nbit  <= 4'h0;
            first <= 1'b0;
        end else if (pc && mgmt_bus_clock && pd && !mgmt_bus_data_in) begin
            nbit  <= 4'h0;
            first <= 1'b1;
        end else if (rise) begin
            sh    <= {sh[6:0], mgmt_bus_data_in};
            nbit  <= (nbit == BIT_ACK) ? 4'h0 : nbit + 4'h1;
            first <= first && (nbit != BIT_ACK);
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    sequence ack_slot;
        rise && first && nbit == BIT_ACK;
    endsequence
    out_zero_a: assert property (disable iff (rst)
        !mgmt_bus_data_out) else $error("data out driven");
    rst_oe_a: assert property (
        rst ##1 rst |=> !mgmt_bus_data_oe) else $error("oe in reset");
    rst_alert_a: assert property (
        rst |=> thermal_alert_out_n) else $error("alert in reset");
    oe_low_a: assert property (disable iff (rst)
        $changed(mgmt_bus_data_oe) |-> !mgmt_bus_clock)
        else $error("oe moved with clock high");
    addr_quiet_a: assert property (disable iff (rst)
        rise && first && nbit != BIT_ACK |-> !mgmt_bus_data_oe)
        else $error("driven during address");
    ack_match_a: assert property (disable iff (rst)
        ack_slot |-> mgmt_bus_data_oe == hit) else $error("wrong ack");
    alert_up_a: assert property (disable iff (rst)
        !$past(rst) && !thermal_alert_out_n
        && diode_temperature >= $past(diode_temperature)
        |=> !thermal_alert_out_n) else $error("alert dropped");
    alert_down_a: assert property (disable iff (rst)
        !$past(rst) && thermal_alert_out_n
        && diode_temperature <= $past(diode_temperature)
        |=> thermal_alert_out_n) else $error("alert raised");
endmodule

bind csad_top csad_checker u_chk (
    .clk_sys, .rst, .mgmt_bus_clock, .mgmt_bus_data_in,
    .mgmt_bus_data_out, .mgmt_bus_data_oe, .slot_select_pins,
    .diode_temperature, .thermal_alert_out_n);

// file: tb/csad_host.sv
// Behavioural management bus host, timed on the link clock
`timescale 1ns/1ps
module csad_host (
    input  logic clk_link,
    input  logic dut_oe,
    output logic scl,
    output logic sda
);
    logic dl = 1'b0;
    int   half = 10;
    // Pulled-up wire: a released line reads high
    assign sda = !(dl || dut_oe);
    initial scl = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_link);
        #1;
    endtask
    // Data moves two ticks after the falling clock, never with it
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        dl = !b;
        tick(half);
        scl = 1'b1;
        tick(half);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start;
        tick(2);
        dl = 1'b0;
        tick(half);
        scl = 1'b1;
        tick(half);
        dl = 1'b1;
        tick(half);
        scl = 1'b0;
    endtask
    task automatic stop;
        tick(2);
        dl = 1'b1;
        tick(half);
        scl = 1'b1;
        tick(half);
        dl = 1'b0;
        tick(half);
    endtask
    // Clock pulses without a frame so new pin levels reach the link side
    task automatic settle;
        repeat (3) begin
            scl = 1'b0;
            tick(half);
            scl = 1'b1;
            tick(half);
        end
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// file: tb/tb_csad_top.sv
// Self-checking bench for the cartridge management bus decoder
`timescale 1ns/1ps
module tb_csad_top
    import csad_pkg::*;
;
    logic            clk_sys = 1'b0;
    logic            clk_link = 1'b0;
    logic            rst = 1'b1;
    logic            wp = 1'b0;
    logic            oe, dout, alert_n, scl, sda, ack;
    logic [7:0]      temp = 8'h00;
    logic [7:0]      sum;
    logic [7:0]      rbuf [14];
    csad_slot_pins_s pins = '0;
    int              n_mismatch = 0;
    int              total_checks = 0;
    localparam logic [7:0] HDR [13] = '{8'h12, 8'h80, 8'h00, 8'h0E, 8'h16,
        8'h26, 8'h33, 8'h3B, 8'h61, 8'h65, 8'h79, 8'h00, 8'h00};
    // Slot pins, address word, expected acknowledge
    // Host keeps off the reserved 0000 nibble
    logic [14:0]     rows [19] = '{
        {6'h00, 8'hA0, 1'b1}, {6'h00, 8'hA3, 1'b1},
        {6'h00, 8'hA4, 1'b0}, {6'h00, 8'h52, 1'b1},
        {6'h00, 8'h30, 1'b0}, {6'h00, 8'h34, 1'b0},
        {6'h3C, 8'hAA, 1'b1}, {6'h3C, 8'hA8, 1'b1},
        {6'h3C, 8'h9D, 1'b1}, {6'h3C, 8'h98, 1'b0},
        {6'h3C, 8'hA2, 1'b0}, {6'h23, 8'hA5, 1'b1},
        {6'h23, 8'hA6, 1'b1}, {6'h23, 8'h31, 1'b1},
        {6'h23, 8'h34, 1'b0}, {6'h2F, 8'hAE, 1'b1},
        {6'h2F, 8'h34, 1'b1}, {6'h0F, 8'h56, 1'b1},
        {6'h0F, 8'h52, 1'b0}};

    always #25 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #16 clk_link = ~clk_link;
    end

    csad_top #(.FORMAT_REV(8'h12)) u_dut (
        .clk_sys, .rst, .mgmt_bus_clock(scl), .mgmt_bus_data_in(sda),
        .mgmt_bus_data_out(dout), .mgmt_bus_data_oe(oe),
        .slot_select_pins(pins), .scratch_write_protect(wp),
        .diode_temperature(temp), .thermal_alert_out_n(alert_n));
    csad_host u_host (.clk_link, .dut_oe(oe), .scl, .sda);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic sys(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, p, d);
        u_host.start();
        u_host.wbyte(a, ack);
        u_host.wbyte(p, ack);
        u_host.wbyte(d, ack);
        u_host.stop();
        chk({7'h00, ack}, 8'h01);
    endtask
    task automatic rd(input logic [7:0] a, p, input int n);
        u_host.start();
        u_host.wbyte(a, ack);
        u_host.wbyte(p, ack);
        u_host.start();
        u_host.wbyte(a | 8'h01, ack);
        for (int i = 0; i < n; i++) u_host.rbyte(i == n - 1, rbuf[i]);
        u_host.stop();
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        sys(16);
        rst = 1'b0;
        sys(4);
        foreach (rows[i]) begin
            pins = rows[i][14:9];
            u_host.settle();
            u_host.start();
            u_host.wbyte(rows[i][8:1], ack);
            if (ack && rows[i][1]) u_host.rbyte(1'b1, rbuf[0]);
            u_host.stop();
            sys(1);
            chk({7'h00, ack}, {7'h00, rows[i][0]});
        end
        pins = '0;
        u_host.settle();
        wr(8'hA0, 8'h05, 8'h5A);
        wr(8'hA0, 8'h06, 8'h3C);
        sys(1);
        wp = 1'b1;
        u_host.half = 16;
        u_host.settle();
        wr(8'hA0, 8'h05, 8'hFF);
        rd(8'hA0, 8'h05, 2);
        chk(rbuf[0], 8'h5A);
        chk(rbuf[1], 8'h3C);
        sys(1);
        wp = 1'b0;
        u_host.half = 10;
        u_host.settle();
        wr(8'hA0, 8'h7F, 8'hC3);
        rd(8'hA0, 8'h7F, 1);
        chk(rbuf[0], 8'hC3);
        wr(8'hA2, 8'h03, 8'hAA);
        rd(8'hA2, 8'h00, 14);
        sum = 8'h00;
        for (int i = 0; i < 13; i++) begin
            chk(rbuf[i], HDR[i]);
            sum += HDR[i];
        end
        chk(rbuf[13], 8'h00 - sum);
        sys(1);
        temp = 8'h4F;
        sys(3);
        chk({7'h00, alert_n}, 8'h01);
        temp = 8'h50;
        sys(3);
        chk({7'h00, alert_n}, 8'h00);
        temp = 8'h4F;
        wr(8'h52, 8'h01, 8'h60);
        rd(8'h52, 8'h01, 1);
        chk(rbuf[0], 8'h60);
        rd(8'h52, 8'h00, 1);
        chk(rbuf[0], 8'h4F);
        sys(8);
        temp = 8'h50;
        sys(3);
        chk({7'h00, alert_n}, 8'h01);
        temp = 8'h60;
        sys(3);
        chk({7'h00, alert_n}, 8'h00);
        rst = 1'b1;
        temp = 8'h55;
        sys(4);
        rst = 1'b0;
        sys(4);
        chk({7'h00, alert_n}, 8'h00);
        end_of_test();
    end
endmodule
